//--- verilog/hbt_defs.svh
`ifndef HBT_DEFS_SVH
`define HBT_DEFS_SVH

// ****************************************
// Register offsets
// ****************************************
`define HBT_ADDR_UNLOCK     8'h0D
`define HBT_ADDR_CFG0       8'h11
`define HBT_ADDR_FULL_SCALE 8'h12
`define HBT_ADDR_SUPPLY_TH  8'h13
`define HBT_ADDR_SKIP_TH    8'h14
`define HBT_ADDR_INI_DELAY  8'h15
`define HBT_ADDR_WIDE_WIN   8'h16
`define HBT_ADDR_NARROW_WIN 8'h17
`define HBT_ADDR_BLANKING   8'h18
`define HBT_ADDR_BRAKE_CYC  8'h19
`define HBT_ADDR_FIRST      8'h0D
`define HBT_ADDR_LAST       8'h19
`define HBT_NUM_REGS        13

// ****************************************
// Writable bit masks, reserved bits clear
// ****************************************
`define HBT_MASK_UNLOCK     8'h01
`define HBT_MASK_CFG0       8'h7F
`define HBT_MASK_FULL       8'hFF
`define HBT_MASK_SKIP_TH    8'h7F
`define HBT_MASK_INI_DELAY  8'h9F
`define HBT_MASK_WIDE_WIN   8'h1F
`define HBT_MASK_NARROW_WIN 8'hF7
`define HBT_MASK_BLANKING   8'h3F
`define HBT_MASK_BRAKE_CYC  8'h1F

// ****************************************
// Field positions
// ****************************************
`define HBT_POS_UNLOCK      0
`define HBT_POS_TWO_POINT   6
`define HBT_POS_EMF_EN      3
`define HBT_POS_ACT_SEL     2
`define HBT_POS_RESTORE_DIS 7
`define HBT_POS_NARROW      4

// ****************************************
// Reset values
// ****************************************
`define HBT_RST_REG         8'h00

// ****************************************
// Timing
// ****************************************
`define HBT_CLK_NS          50
`define HBT_BLANK_LSB_NS    5000
`define HBT_BLANK_STEP_CYC  ((`HBT_BLANK_LSB_NS + `HBT_CLK_NS - 1) / `HBT_CLK_NS)
`define HBT_WIN_SHIFT       5
`define HBT_BLANK_CAP_SHIFT 6

`endif

//--- verilog/hbt_pkg.sv
package hbt_pkg;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } hbt_reg_req_t;

  typedef struct packed {
    logic       fault_unlock_bit;
    logic       brake_two_point_measure;
    logic       resonance_detect_enable;
    logic       actuator_type_select;
    logic [7:0] full_scale_voltage;
    logic [7:0] supply_disable_level;
    logic [6:0] detect_skip_threshold;
    logic       guess_restore_disable;
    logic [4:0] initial_delay_half_periods;
    logic [4:0] wide_window_length;
    logic [3:0] narrow_window_length;
    logic [2:0] post_detect_skip_count;
    logic [5:0] blanking_length;
    logic [4:0] braking_half_periods;
  } hbt_cfg_t;

  typedef struct packed {
    logic drive_request;
    logic half_period_tick;
    logic pattern_start;
    logic polarity_change;
    logic detect_done;
    logic window_start;
    logic window_narrow;
  } hbt_evt_t;

endpackage : hbt_pkg

//--- verilog/hbt_regfile.sv
`timescale 1ns/1ns
`include "hbt_defs.svh"

module hbt_regfile (
  input  wire logic               clk,
  input  wire logic               srst,
  input  wire hbt_pkg::hbt_reg_req_t req,
  input  wire logic               unlock_clr,
  output logic [7:0]              rdata,
  output hbt_pkg::hbt_cfg_t       cfg
);
  import hbt_pkg::*;

  typedef struct packed {
    logic [`HBT_NUM_REGS-1:0][7:0] mem;
    logic [7:0]                    rdata;
  } hbt_rf_state_t;

  hbt_rf_state_t st_q;
  hbt_rf_state_t st_d;

  // Unmapped and reserved offsets answer zero
  function automatic logic [7:0] wmask(input logic [7:0] a);
    case (a)
      `HBT_ADDR_UNLOCK:     wmask = `HBT_MASK_UNLOCK;
      `HBT_ADDR_CFG0:       wmask = `HBT_MASK_CFG0;
      `HBT_ADDR_FULL_SCALE: wmask = `HBT_MASK_FULL;
      `HBT_ADDR_SUPPLY_TH:  wmask = `HBT_MASK_FULL;
      `HBT_ADDR_SKIP_TH:    wmask = `HBT_MASK_SKIP_TH;
      `HBT_ADDR_INI_DELAY:  wmask = `HBT_MASK_INI_DELAY;
      `HBT_ADDR_WIDE_WIN:   wmask = `HBT_MASK_WIDE_WIN;
      `HBT_ADDR_NARROW_WIN: wmask = `HBT_MASK_NARROW_WIN;
      `HBT_ADDR_BLANKING:   wmask = `HBT_MASK_BLANKING;
      `HBT_ADDR_BRAKE_CYC:  wmask = `HBT_MASK_BRAKE_CYC;
      default:              wmask = 8'h00;
    endcase
  endfunction : wmask

  function automatic logic [3:0] idx(input logic [7:0] a);
    idx = 4'(a - `HBT_ADDR_FIRST);
  endfunction : idx

  function automatic logic [7:0] rd(input hbt_rf_state_t s, input logic [7:0] a);
    rd = s.mem[idx(a)];
  endfunction : rd

  always_comb begin
    st_d = st_q;
    if (unlock_clr) begin
      st_d.mem[idx(`HBT_ADDR_UNLOCK)][`HBT_POS_UNLOCK] = 1'b0;
    end
    // Reserved bits never store
    if (req.wr && wmask(req.addr) != 8'h00) begin
      st_d.mem[idx(req.addr)] = req.wdata & wmask(req.addr);
    end
    if (req.rd) begin
      st_d.rdata = (wmask(req.addr) != 8'h00) ? rd(st_q, req.addr) : 8'h00;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      st_q.mem   <= {`HBT_NUM_REGS{`HBT_RST_REG}};
      st_q.rdata <= 8'h00;
    end else begin
      st_q <= st_d;
    end
  end

  assign rdata = st_q.rdata;

  always_comb begin
    cfg.fault_unlock_bit           = st_q.mem[idx(`HBT_ADDR_UNLOCK)][`HBT_POS_UNLOCK];
    cfg.brake_two_point_measure    = st_q.mem[idx(`HBT_ADDR_CFG0)][`HBT_POS_TWO_POINT];
    cfg.resonance_detect_enable    = st_q.mem[idx(`HBT_ADDR_CFG0)][`HBT_POS_EMF_EN];
    cfg.actuator_type_select       = st_q.mem[idx(`HBT_ADDR_CFG0)][`HBT_POS_ACT_SEL];
    cfg.full_scale_voltage         = st_q.mem[idx(`HBT_ADDR_FULL_SCALE)];
    cfg.supply_disable_level       = st_q.mem[idx(`HBT_ADDR_SUPPLY_TH)];
    cfg.detect_skip_threshold      = st_q.mem[idx(`HBT_ADDR_SKIP_TH)][6:0];
    cfg.guess_restore_disable      = st_q.mem[idx(`HBT_ADDR_INI_DELAY)][`HBT_POS_RESTORE_DIS];
    cfg.initial_delay_half_periods = st_q.mem[idx(`HBT_ADDR_INI_DELAY)][4:0];
    cfg.wide_window_length         = st_q.mem[idx(`HBT_ADDR_WIDE_WIN)][4:0];
    cfg.narrow_window_length       = st_q.mem[idx(`HBT_ADDR_NARROW_WIN)][`HBT_POS_NARROW +: 4];
    cfg.post_detect_skip_count     = st_q.mem[idx(`HBT_ADDR_NARROW_WIN)][2:0];
    cfg.blanking_length            = st_q.mem[idx(`HBT_ADDR_BLANKING)][5:0];
    cfg.braking_half_periods       = st_q.mem[idx(`HBT_ADDR_BRAKE_CYC)][4:0];
  end

endmodule : hbt_regfile

//--- verilog/hbt_core.sv
`timescale 1ns/1ns
`include "hbt_defs.svh"

// Functional notes
// - An eight-bit full-scale drive voltage register, 21.57mV per step, is the amplitude reference.
// - The effective full scale is the smaller of that setting and the measured haptic supply.
// - Supply below the eight-bit disable level locks the driver off, pulses the interrupt and sets the fault flag.
// - After a lockout the driver only restarts once software has written the unlock bit to 1.
// - Detection is skipped while the lower seven amplitude bits are below the seven-bit skip threshold.
// - With restore-disable 0 the initial guess is reloaded when braking ends, with 1 the frequency is kept.
// - A five-bit count of half periods is skipped after pattern start, polarity change or amplitude recovery.
// - The wide window lasts its five-bit field times one thirty-second of the sine period.
// - The narrow window lasts its four-bit field times one thirty-second of the sine period.
// - After each detection outside braking a three-bit count of half periods is skipped.
// - The comparator is blanked for six-bit field times 128 cycles of 25.6MHz after window entry and before exit.
// - Blanking is capped at one sixty-fourth of the period except when braking with two-point measurement.
// - The unlock bit returns to 0 by itself two cycles after it is stored, whether or not the fault flag has cleared.
// - Actuator select 0 is eccentric mass, 1 is linear resonant; the enable bit turns detection on in linear resonant mode only.
// - While braking half periods run, the initial-delay and post-detection skips are masked.
module hbt_core (
  input  wire logic                  clk,
  input  wire logic                  srst,
  input  wire hbt_pkg::hbt_reg_req_t reg_req,
  output logic [7:0]                 reg_rdata,
  input  wire logic [7:0]            supply_level,
  input  wire logic [7:0]            output_amplitude,
  input  wire logic [15:0]           period_cycles,
  input  wire hbt_pkg::hbt_evt_t     evt,
  output logic [7:0]                 effective_full_scale,
  output logic                       driver_enable,
  output logic                       driver_fault_flag,
  output logic                       supply_low_interrupt,
  output logic                       lra_mode,
  output logic                       detect_allow,
  output logic                       braking_active,
  output logic                       load_initial_guess,
  output logic [15:0]                wide_window_cycles,
  output logic [15:0]                narrow_window_cycles,
  output logic [15:0]                blank_cycles,
  output logic                       window_active,
  output logic                       comparator_blank
);
  import hbt_pkg::*;

  typedef struct packed {
    logic        fault;
    logic        irq;
    logic        unlock_clr;
    logic        enable;
    logic        below;
    logic [4:0]  skip_cnt;
    logic [4:0]  brk_cnt;
    logic        restore;
    logic        allow;
    logic [7:0]  vfs_eff;
    logic [15:0] wide_len;
    logic [15:0] narrow_len;
    logic [15:0] blank_len;
    logic [15:0] win_left;
    logic [15:0] win_used;
    logic        win_act;
    logic        blank;
  } hbt_state_t;

  hbt_state_t st_q;
  hbt_state_t st_d;
  hbt_cfg_t   cfg;

  logic        below_now;
  logic        fault_set;
  logic        brake_end;
  logic [15:0] blank_req;
  logic [15:0] blank_cap;
  logic [15:0] new_len;
  logic        lra_sel_q;

  // ****************************************
  // Register file
  // ****************************************
  hbt_regfile u_regs (
    .clk        (clk),
    .srst       (srst),
    .req        (reg_req),
    .unlock_clr (st_q.unlock_clr),
    .rdata      (reg_rdata),
    .cfg        (cfg)
  );

  // Window length in clock cycles from a field in 1/32 period steps
  function automatic logic [15:0] win_cycles(input logic [4:0] field, input logic [15:0] period);
    logic [20:0] prod;
    prod       = 21'(field) * 21'(period);
    win_cycles = prod[`HBT_WIN_SHIFT +: 16];
  endfunction : win_cycles

  // ****************************************
  // Next state
  // ****************************************
  always_comb begin
    st_d = st_q;

    // Full scale tracks a sagging supply
    st_d.vfs_eff = (cfg.full_scale_voltage < supply_level) ? cfg.full_scale_voltage
                                                           : supply_level;

    // Lockout; a live undervoltage beats the unlock
    fault_set        = supply_level < cfg.supply_disable_level;
    st_d.fault       = fault_set || (st_q.fault && !cfg.fault_unlock_bit);
    st_d.irq         = fault_set && !st_q.fault;
    st_d.unlock_clr  = cfg.fault_unlock_bit && !st_q.unlock_clr;
    st_d.enable      = evt.drive_request && !st_d.fault;

    // Amplitude magnitude versus skip threshold
    below_now  = output_amplitude[6:0] < cfg.detect_skip_threshold;
    st_d.below = below_now;

    // Braking half periods after a polarity flip
    brake_end = evt.half_period_tick && st_q.brk_cnt == 5'd1;
    if (evt.polarity_change) begin
      st_d.brk_cnt = cfg.braking_half_periods;
    end else if (evt.half_period_tick && st_q.brk_cnt != 5'd0) begin
      st_d.brk_cnt = st_q.brk_cnt - 5'd1;
    end
    st_d.restore = brake_end && !evt.polarity_change && !cfg.guess_restore_disable;

    // Skip counting; held still during braking so it takes effect afterwards
    if (evt.pattern_start || evt.polarity_change || (st_q.below && !below_now)) begin
      st_d.skip_cnt = cfg.initial_delay_half_periods;
    end else if (evt.detect_done && st_q.brk_cnt == 5'd0) begin
      st_d.skip_cnt = 5'(cfg.post_detect_skip_count);
    end else if (evt.half_period_tick && st_q.skip_cnt != 5'd0 && st_q.brk_cnt == 5'd0) begin
      st_d.skip_cnt = st_q.skip_cnt - 5'd1;
    end

    st_d.allow = cfg.resonance_detect_enable && cfg.actuator_type_select && st_d.enable
                 && !below_now
                 && (st_d.brk_cnt != 5'd0 || st_d.skip_cnt == 5'd0);

    // Window and blanking lengths
    st_d.wide_len   = win_cycles(cfg.wide_window_length, period_cycles);
    st_d.narrow_len = win_cycles({1'b0, cfg.narrow_window_length}, period_cycles);
    blank_req       = 16'(cfg.blanking_length) * 16'(`HBT_BLANK_STEP_CYC);
    blank_cap       = period_cycles >> `HBT_BLANK_CAP_SHIFT;
    if (st_q.brk_cnt != 5'd0 && cfg.brake_two_point_measure) begin
      st_d.blank_len = blank_req;
    end else begin
      st_d.blank_len = (blank_req < blank_cap) ? blank_req : blank_cap;
    end

    // Window timer; a new start restarts the window
    new_len = evt.window_narrow ? st_q.narrow_len : st_q.wide_len;
    if (evt.window_start) begin
      st_d.win_left = new_len;
      st_d.win_used = 16'h0000;
    end else if (st_q.win_left != 16'h0000) begin
      st_d.win_left = st_q.win_left - 16'h0001;
      st_d.win_used = st_q.win_used + 16'h0001;
    end
    st_d.win_act = st_d.win_left != 16'h0000;
    // Blank the head and the tail of each window
    st_d.blank   = st_d.win_act && (st_d.win_used < st_q.blank_len
                                    || st_d.win_left <= st_q.blank_len);
  end

  // ****************************************
  // State register
  // ****************************************
  always_ff @(posedge clk) begin
    if (srst) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign effective_full_scale = st_q.vfs_eff;
  assign driver_enable        = st_q.enable;
  assign driver_fault_flag    = st_q.fault;
  assign supply_low_interrupt = st_q.irq;
  assign lra_mode             = lra_sel_q;
  assign detect_allow         = st_q.allow;
  assign braking_active       = st_q.brk_cnt != 5'd0 ? 1'b1 : 1'b0;
  assign load_initial_guess   = st_q.restore;
  assign wide_window_cycles   = st_q.wide_len;
  assign narrow_window_cycles = st_q.narrow_len;
  assign blank_cycles         = st_q.blank_len;
  assign window_active        = st_q.win_act;
  assign comparator_blank     = st_q.blank;

  // Mode select mirrored from its register bit
  always_ff @(posedge clk) begin
    if (srst) begin
      lra_sel_q <= 1'b0;
    end else begin
      lra_sel_q <= cfg.actuator_type_select;
    end
  end

endmodule : hbt_core

//--- test/hbt_core_props.sv
`timescale 1ns/1ns
`include "hbt_defs.svh"

// ****
// Checker
// ****
module hbt_core_props (
  input wire logic                  clk,
  input wire logic                  srst,
  input wire hbt_pkg::hbt_reg_req_t reg_req,
  input wire logic [7:0]            supply_level,
  input wire logic [15:0]           period_cycles,
  input wire hbt_pkg::hbt_evt_t     evt,
  input wire logic [7:0]            effective_full_scale,
  input wire logic                  driver_enable,
  input wire logic                  driver_fault_flag,
  input wire logic                  supply_low_interrupt,
  input wire logic                  braking_active,
  input wire logic                  load_initial_guess,
  input wire logic [15:0]           wide_window_cycles,
  input wire logic [15:0]           narrow_window_cycles,
  input wire logic [15:0]           blank_cycles,
  input wire logic                  window_active,
  input wire logic                  comparator_blank
);
  import hbt_pkg::*;
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);
  logic unlock_wr;
  assign unlock_wr = reg_req.wr && reg_req.addr == `HBT_ADDR_UNLOCK && reg_req.wdata[0];

  a_fs_min: assert property (effective_full_scale <= $past(supply_level))
    else $error("full scale above supply");
  a_irq_on_fault: assert property (supply_low_interrupt |-> driver_fault_flag && !$past(driver_fault_flag))
    else $error("interrupt without new fault");
  a_fault_blocks: assert property (driver_fault_flag |-> !driver_enable)
    else $error("driver on during fault");
  a_fault_unlock: assert property ($fell(driver_fault_flag) |-> $past(unlock_wr, 2))
    else $error("fault cleared without unlock");
  a_guess_at_end: assert property (load_initial_guess |-> $fell(braking_active) ##1 !load_initial_guess)
    else $error("guess reload out of place");
  a_wide_bound: assert property (wide_window_cycles <= $past(period_cycles))
    else $error("wide window too long");
  a_narrow_bound: assert property (narrow_window_cycles <= ($past(period_cycles) >> 1))
    else $error("narrow window too long");
  a_blank_cap: assert property (!$past(braking_active) |-> blank_cycles <= ($past(period_cycles) >> 6))
    else $error("blanking above cap");
  a_blank_inside: assert property (comparator_blank |-> window_active)
    else $error("blanking outside window");
  a_window_go: assert property (evt.window_start && !evt.window_narrow && wide_window_cycles != 0
    |=> window_active)
    else $error("window did not start");
  c_fault: cover property (supply_low_interrupt);
  c_guess: cover property (load_initial_guess);
  c_window: cover property (window_active && comparator_blank);
endmodule : hbt_core_props

bind hbt_core hbt_core_props u_props (.clk(clk), .srst(srst), .reg_req(reg_req), .supply_level(supply_level),
  .period_cycles(period_cycles), .evt(evt), .effective_full_scale(effective_full_scale),
  .driver_enable(driver_enable), .driver_fault_flag(driver_fault_flag),
  .supply_low_interrupt(supply_low_interrupt), .braking_active(braking_active),
  .load_initial_guess(load_initial_guess), .wide_window_cycles(wide_window_cycles),
  .narrow_window_cycles(narrow_window_cycles), .blank_cycles(blank_cycles),
  .window_active(window_active), .comparator_blank(comparator_blank));

//--- test/hbt_actuator_model.sv
`timescale 1ns/1ns

// ****
// Drive engine and actuator stand-in
// ****
module hbt_actuator_model #(
  parameter int PERIOD = 12800
) (
  input  wire logic  clk,
  input  wire logic  srst,
  input  wire logic  run,
  output logic       tick,
  output logic [15:0] period
);
  int cnt_q;
  assign period = 16'(PERIOD);
  // Sine only advances while the driver is on
  always @(posedge clk) begin
    tick <= 1'b0;
    if (srst || !run) begin
      cnt_q <= 0;
    end else if (cnt_q == PERIOD / 2 - 1) begin
      cnt_q <= 0;
      tick  <= 1'b1;
    end else begin
      cnt_q <= cnt_q + 1;
    end
  end
endmodule : hbt_actuator_model

//--- test/hbt_core_tb.sv
`timescale 1ns/1ns

module hbt_core_tb;
  import hbt_pkg::*;
  logic clk = 0;
  logic srst = 1;
  hbt_reg_req_t req = '0;
  logic [7:0] supply = 8'hA0;
  logic [7:0] amp = 8'h40;
  hbt_evt_t ev = '0;
  hbt_evt_t evt_w;
  logic tick;
  logic [15:0] per, wwc, nwc, bc;
  logic [7:0] rdata, efs;
  logic en, flt, irq, lra, dal, brk, lig, wa, cb;
  int failures = 0;
  int checks_done = 0;
  int cycles = 0;

  assign evt_w = hbt_evt_t'({ev.drive_request, tick, ev[4:0]});
  always #25 clk = ~clk;
  always @(posedge clk) begin
    cycles++;
    if (cycles == 80000) begin
      failures++;
      stop_test();
    end
  end

  hbt_actuator_model u_act (.clk(clk), .srst(srst), .run(en), .tick(tick), .period(per));
  hbt_core u_dut (.clk(clk), .srst(srst), .reg_req(req), .reg_rdata(rdata), .supply_level(supply),
    .output_amplitude(amp), .period_cycles(per), .evt(evt_w), .effective_full_scale(efs),
    .driver_enable(en), .driver_fault_flag(flt), .supply_low_interrupt(irq), .lra_mode(lra),
    .detect_allow(dal), .braking_active(brk), .load_initial_guess(lig), .wide_window_cycles(wwc),
    .narrow_window_cycles(nwc), .blank_cycles(bc), .window_active(wa), .comparator_blank(cb));

  // ****
  // Helpers
  // ****
  task step; @(posedge clk); #5; endtask : step
  task chk(input string n, input logic [15:0] s, input logic [15:0] e);
    checks_done++;
    if (s !== e) begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  // Idle cycle after each strobe so no signal is set twice in one step
  task wr(input logic [7:0] a, input logic [7:0] d);
    req = '{1'b1, 1'b0, a, d}; step; req = '0; step;
  endtask : wr
  task rd(input logic [7:0] a, input logic [7:0] e);
    req = '{1'b0, 1'b1, a, 8'h00}; step; req = '0;
    chk("rdata", {8'h00, rdata}, {8'h00, e}); step;
  endtask : rd
  task stop_test;
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : stop_test

  // ****
  // Scenarios
  // ****
  task t_regs;
    logic [7:0] m [7];
    m = '{8'hFF, 8'hFF, 8'h7F, 8'h9F, 8'h1F, 8'hF7, 8'h3F};
    for (int i = 0; i < 7; i++) begin
      rd(8'(8'h12 + i), 8'h00);
      wr(8'(8'h12 + i), 8'hFF);
      rd(8'(8'h12 + i), m[i]);
    end
    wr(8'h1A, 8'hFF);
    rd(8'h1A, 8'h00);
    // Threshold 0xFF above the supply latched a fault; drop it and unlock
    wr(8'h13, 8'h00); wr(8'h0D, 8'h01); step; step;
    chk("fault", flt, 0);
  endtask : t_regs
  task t_fault;
    wr(8'h12, 8'h80); wr(8'h13, 8'h40); supply = 8'h60; step; step;
    chk("efs", efs, 8'h60);
    supply = 8'hA0; step; step;
    chk("efs", efs, 8'h80);
    ev.drive_request = 1; step; step;
    chk("enable", en, 1);
    supply = 8'h30; step;
    chk("fault", flt, 1); chk("irq", irq, 1); chk("enable", en, 0);
    step; chk("irq", irq, 0);
    supply = 8'hA0; step; step;
    chk("fault", flt, 1); chk("enable", en, 0);
    wr(8'h0D, 8'h01);
    chk("fault", flt, 0);
    step; step; rd(8'h0D, 8'h00);
    chk("enable", en, 1);
  endtask : t_fault
  task t_window;
    int n;
    wr(8'h16, 8'h08); wr(8'h17, 8'h47); wr(8'h18, 8'h01); step;
    chk("wide", wwc, 16'd3200); chk("narrow", nwc, 16'd1600);
    chk("blank", bc, 16'd100);
    wr(8'h18, 8'h03); step;
    chk("blank", bc, 16'd200);
    ev.window_narrow = 1; ev.window_start = 1; step; ev.window_start = 0;
    chk("blanked", cb, 1);
    n = 0;
    while (wa === 1'b1 && n < 5000) begin n++; step; end
    chk("narrow len", 16'(n), 16'd1600);
  endtask : t_window
  task t_brake(input logic rdis, input logic exp);
    int n;
    logic seen;
    wr(8'h11, 8'h0C); wr(8'h19, 8'h02); wr(8'h15, {rdis, 7'h00}); wr(8'h14, 8'h10);
    chk("lra", lra, 1);
    ev.polarity_change = 1; step; ev.polarity_change = 0;
    chk("braking", brk, 1);
    seen = 0; n = 0;
    while (brk === 1'b1 && n < 20000) begin if (lig === 1'b1) seen = 1; n++; step; end
    if (lig === 1'b1) seen = 1;
    chk("braking", brk, 0); chk("guess", seen, exp);
  endtask : t_brake
  task t_skip;
    int n;
    step; step; chk("allow", dal, 1);
    amp = 8'h8F; step; step; chk("allow", dal, 0);
    wr(8'h15, 8'h01); amp = 8'h40; step; step;
    chk("allow", dal, 0);
    n = 0;
    while (dal !== 1'b1 && n < 14000) begin n++; step; end
    chk("allow", dal, 1);
    ev.detect_done = 1; step; ev.detect_done = 0; step;
    chk("allow", dal, 0);
    wr(8'h11, 8'h04); step; chk("allow", dal, 0);
  endtask : t_skip

  initial begin
    repeat (16) @(posedge clk);
    #5 srst = 0;
    t_regs(); t_fault(); t_window(); t_brake(0, 1); t_brake(1, 0); t_skip();
    stop_test();
  end
endmodule : hbt_core_tb
